// ===== verilog/sb_pkg.sv
// Shared constants and types for the settings register bank.
package sb_pkg;

	// Clock and time base.
	localparam int SB_CLK_PERIOD_NS = 4;
	localparam int SB_CLK_HZ = 250000000;
	localparam int SB_MS_NS = 1000000;
	localparam int SB_MS_CYCLES = SB_MS_NS / SB_CLK_PERIOD_NS;
	localparam int SB_MINUTE_MS = 60000;

	// Register count and index of each holding register.
	localparam int SB_NREG = 11;
	localparam int SB_IDX_VALVE_DELAY = 0;
	localparam int SB_IDX_BATT_RECOVER = 1;
	localparam int SB_IDX_BATT_LOW = 2;
	localparam int SB_IDX_NODE_ADDR = 3;
	localparam int SB_IDX_BIT_RATE = 4;
	localparam int SB_IDX_WORD_ORDER = 5;
	localparam int SB_IDX_DAY_HOUR = 6;
	localparam int SB_IDX_DL_SELECT = 7;
	localparam int SB_IDX_LOG_MIN = 8;
	localparam int SB_IDX_SPAN = 9;
	localparam int SB_IDX_ZERO = 10;

	// Register numbers, in index order.
	localparam logic [15:0] SB_REG_OFS [SB_NREG] = '{
		16'h00a4, 16'h00aa, 16'h00ab, 16'h00af, 16'h00b0, 16'h00b1,
		16'h00b4, 16'h00b5, 16'h00b6, 16'h00b9, 16'h00ba};
	// First and last register number of the bank; gaps between read as zero.
	localparam logic [15:0] SB_OFS_FIRST = 16'h00a4;
	localparam logic [15:0] SB_OFS_LAST = 16'h00ba;

	// Values after reset.
	localparam logic [15:0] SB_BIT_RATE_RST = 16'h0002;
	localparam logic [15:0] SB_REG_RST [SB_NREG] = '{
		16'h0064, 16'h30d4, 16'h2cec, 16'h0001, SB_BIT_RATE_RST, 16'h0000,
		16'h0000, 16'h0000, 16'h003c, 16'h0320, 16'h0000};
	// Accepted range of each register.
	localparam logic [15:0] SB_REG_MIN [SB_NREG] = '{
		16'h0000, 16'h2710, 16'h2710, 16'h0001, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0005, 16'h8000, 16'h8000};
	localparam logic [15:0] SB_REG_MAX [SB_NREG] = '{
		16'h03e8, 16'h7530, 16'h61a8, 16'h00f7, 16'h0007, 16'h0001,
		16'h0017, 16'h0001, 16'h003c, 16'h7fff, 16'h7fff};
	localparam logic SB_REG_SIGNED [SB_NREG] = '{
		1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

	// Bit rates selected by the 3-bit code.
	localparam int SB_BAUD [8] = '{2400, 4800, 9600, 19200, 38400, 57600, 115200, 230400};

	// Default right shift applied to the span product.
	localparam int SB_SPAN_SHIFT = 10;

	// Valve drive sequence.
	typedef enum logic [1:0] {
		SB_VALVE_IDLE = 2'b00,
		SB_VALVE_FULL_ON = 2'b01,
		SB_VALVE_PWM = 2'b10
	} sb_valve_t;

	// Clock cycles per bit for a bit-rate code.
	function automatic logic [19:0] sb_bit_cycles(input logic [2:0] code);
		int div;
		div = SB_CLK_HZ / SB_BAUD[code];
		return div[19:0];
	endfunction

endpackage

// ===== verilog/sb_cfg_reg.sv
// One range-checked 16-bit holding register.
`timescale 1ns/1ps
module sb_cfg_reg #(
	parameter logic [15:0] RESET_VAL = 16'h0000,
	parameter logic [15:0] MIN_VAL = 16'h0000,
	parameter logic [15:0] MAX_VAL = 16'hffff,
	parameter logic SIGNED_RANGE = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [15:0] wdata,
	output logic [15:0] value,
	output logic in_range
);
	import sb_pkg::*;

	typedef struct packed {
		logic [15:0] value;
	} sb_cfg_state_t;

	sb_cfg_state_t s;
	sb_cfg_state_t next_s;

	// Signed fields compare as two's complement, the rest as plain counts.
	always_comb begin
		if (SIGNED_RANGE) begin
			in_range = ($signed(wdata) >= $signed(MIN_VAL)) && ($signed(wdata) <= $signed(MAX_VAL));
		end else begin
			in_range = (wdata >= MIN_VAL) && (wdata <= MAX_VAL);
		end
		next_s = s;
		if (wr_en && in_range) begin
			next_s.value = wdata;
		end
	end

	// Register the state; reset loads the documented default.
	always_ff @(posedge clk) begin
		if (rst) begin
			s.value <= RESET_VAL;
		end else begin
			s <= next_s;
		end
	end

	assign value = s.value;

endmodule

// ===== verilog/sb_settings_bank.sv
// Settings register bank with the behaviour its settings steer.
// Notes on behaviour
// - Valve held fully on for programmed milliseconds before PWM; 0 to 1000, default 100.
// - Low-battery state left only when voltage is at or above recovery level.
// - Low-battery state entered when voltage is at or below low level.
// - Bus node address 1 to 247, default 1, answers the field bus.
// - Three-bit code selects bit rate 2400 up to 230400 bits per second.
// - Word order 1 sends most significant word first; 0, default, least first.
// - Download select 0 delivers new log records only; 1 delivers all.
// - A log record is created every programmed minutes; 5 to 60, default 60.
// - Signed span calibration, default 800, scales the transducer measurement.
// - Signed zero offset, default 0, is added to the transducer measurement.
`timescale 1ns/1ps
module sb_settings_bank #(
	parameter int CYCLES_PER_MS = sb_pkg::SB_MS_CYCLES,
	parameter int MINUTE_MS = sb_pkg::SB_MINUTE_MS,
	parameter int SPAN_SHIFT = sb_pkg::SB_SPAN_SHIFT
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	output logic REG_ACK,
	output logic REG_ERR,
	input wire logic [15:0] BATT_MV,
	output logic LOW_BATTERY,
	input wire logic VALVE_REQ,
	output logic VALVE_FULL_ON,
	output logic VALVE_PWM_EN,
	output logic [7:0] NODE_ADDRESS,
	output logic [19:0] BIT_CYCLES,
	input wire logic [15:0] SENSOR_RAW,
	output logic [31:0] SENSOR_CAL,
	output logic [15:0] TX_WORD_FIRST,
	output logic [15:0] TX_WORD_SECOND,
	output logic LOG_SEND_ALL,
	output logic [4:0] LOG_DAY_HOUR,
	output logic LOG_TICK
);
	import sb_pkg::*;

	typedef struct packed {
		logic [15:0] rdata;
		logic ack;
		logic err;
		logic low_batt;
		sb_valve_t valve;
		logic [31:0] valve_cyc;
		logic [15:0] valve_ms;
		logic [31:0] log_cyc;
		logic [31:0] log_ms;
		logic [15:0] log_min;
		logic log_tick;
		logic [19:0] bit_cycles;
		logic [31:0] sensor;
		logic [15:0] tx_first;
		logic [15:0] tx_second;
	} sb_main_state_t;

	// Reset state; the bit period restarts at the default code, so the line
	// timing never sees a zero period while the bank comes out of reset.
	localparam logic [19:0] RST_BIT_CYCLES = sb_bit_cycles(SB_BIT_RATE_RST[2:0]);
	localparam sb_main_state_t RST_STATE = '{
		valve: SB_VALVE_IDLE,
		bit_cycles: RST_BIT_CYCLES,
		default: '0
	};

	sb_main_state_t s;
	sb_main_state_t next_s;

	logic [15:0] reg_val [SB_NREG];
	logic [SB_NREG-1:0] reg_ok;
	logic [SB_NREG-1:0] reg_wr;
	logic [SB_NREG-1:0] reg_hit;
	logic [31:0] span_prod;
	logic [31:0] scaled;

	// One range-checked register per setting.
	for (genvar i = 0; i < SB_NREG; i++) begin : g_reg
		assign reg_hit[i] = (REG_ADDR == SB_REG_OFS[i]);
		assign reg_wr[i] = REG_WR && reg_hit[i];
		sb_cfg_reg #(
			.RESET_VAL(SB_REG_RST[i]),
			.MIN_VAL(SB_REG_MIN[i]),
			.MAX_VAL(SB_REG_MAX[i]),
			.SIGNED_RANGE(SB_REG_SIGNED[i])
		) u_reg (
			.clk(SYS_CLK),
			.rst(SYS_RST),
			.wr_en(reg_wr[i]),
			.wdata(REG_WDATA),
			.value(reg_val[i]),
			.in_range(reg_ok[i])
		);
	end

	// Span multiplies, then the zero offset nulls the result.
	assign span_prod = 32'($signed(SENSOR_RAW) * $signed(reg_val[SB_IDX_SPAN]));
	assign scaled = 32'($signed(span_prod) >>> SPAN_SHIFT);

	// Next-state logic for the register port, battery, valve, log timer and sensor.
	always_comb begin
		next_s = s;
		next_s.ack = 1'b0;
		next_s.err = 1'b0;
		next_s.log_tick = 1'b0;

		// Register access: a read of a gap inside the bank gives zero; an address outside the bank, a write to a gap or an out-of-range value is an error.
		if (REG_RD || REG_WR) begin
			next_s.ack = 1'b1;
			next_s.rdata = 16'h0000;
			if (REG_ADDR < SB_OFS_FIRST || REG_ADDR > SB_OFS_LAST) begin
				next_s.err = 1'b1;
			end else if (REG_WR) begin
				next_s.err = ~|(reg_hit & reg_ok);
			end else begin
				for (int i = 0; i < SB_NREG; i++) begin
					if (reg_hit[i]) begin
						next_s.rdata = reg_val[i];
					end
				end
			end
		end

		// Hysteresis: the recover level ends the state, the low level starts it.
		if (!s.low_batt && BATT_MV <= reg_val[SB_IDX_BATT_LOW]) begin
			next_s.low_batt = 1'b1;
		end else if (s.low_batt && BATT_MV >= reg_val[SB_IDX_BATT_RECOVER]) begin
			next_s.low_batt = 1'b0;
		end

		// Valve sequence; its own millisecond counter starts at the request edge.
		case (s.valve)
			SB_VALVE_IDLE: begin
				next_s.valve_cyc = 32'h0000_0000;
				next_s.valve_ms = 16'h0000;
				if (VALVE_REQ) begin
					if (reg_val[SB_IDX_VALVE_DELAY] == 16'h0000) begin
						next_s.valve = SB_VALVE_PWM;
					end else begin
						next_s.valve = SB_VALVE_FULL_ON;
					end
				end
			end
			SB_VALVE_FULL_ON: begin
				if (!VALVE_REQ) begin
					next_s.valve = SB_VALVE_IDLE;
				end else if (s.valve_cyc == 32'(CYCLES_PER_MS - 1)) begin
					next_s.valve_cyc = 32'h0000_0000;
					next_s.valve_ms = s.valve_ms + 16'h0001;
					if (s.valve_ms + 16'h0001 >= reg_val[SB_IDX_VALVE_DELAY]) begin
						next_s.valve = SB_VALVE_PWM;
					end
				end else begin
					next_s.valve_cyc = s.valve_cyc + 32'h0000_0001;
				end
			end
			SB_VALVE_PWM: begin
				if (!VALVE_REQ) begin
					next_s.valve = SB_VALVE_IDLE;
				end
			end
			default: begin
				next_s.valve = SB_VALVE_IDLE;
			end
		endcase

		// Log interval: a shortened interval takes effect at the next minute.
		if (s.log_cyc == 32'(CYCLES_PER_MS - 1)) begin
			next_s.log_cyc = 32'h0000_0000;
			if (s.log_ms == 32'(MINUTE_MS - 1)) begin
				next_s.log_ms = 32'h0000_0000;
				if (s.log_min + 16'h0001 >= reg_val[SB_IDX_LOG_MIN]) begin
					next_s.log_min = 16'h0000;
					next_s.log_tick = 1'b1;
				end else begin
					next_s.log_min = s.log_min + 16'h0001;
				end
			end else begin
				next_s.log_ms = s.log_ms + 32'h0000_0001;
			end
		end else begin
			next_s.log_cyc = s.log_cyc + 32'h0000_0001;
		end

		next_s.bit_cycles = sb_bit_cycles(reg_val[SB_IDX_BIT_RATE][2:0]);
		next_s.sensor = scaled + 32'($signed(reg_val[SB_IDX_ZERO]));

		// Send order is registered with the value itself, so both words always
		// belong to one measurement, even while the order setting changes.
		if (reg_val[SB_IDX_WORD_ORDER][0]) begin
			next_s.tx_first = next_s.sensor[31:16];
			next_s.tx_second = next_s.sensor[15:0];
		end else begin
			next_s.tx_first = next_s.sensor[15:0];
			next_s.tx_second = next_s.sensor[31:16];
		end
	end

	// Register the state; everything clears on reset except the bit period.
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			s <= RST_STATE;
		end else begin
			s <= next_s;
		end
	end

	// Outputs; node address, download select and day-hour come straight from their registers, the bit period through the state.
	assign REG_RDATA = s.rdata;
	assign REG_ACK = s.ack;
	assign REG_ERR = s.err;
	assign LOW_BATTERY = s.low_batt;
	assign VALVE_FULL_ON = (s.valve == SB_VALVE_FULL_ON);
	assign VALVE_PWM_EN = (s.valve == SB_VALVE_PWM);
	assign NODE_ADDRESS = reg_val[SB_IDX_NODE_ADDR][7:0];
	assign BIT_CYCLES = s.bit_cycles;
	assign SENSOR_CAL = s.sensor;
	assign TX_WORD_FIRST = s.tx_first;
	assign TX_WORD_SECOND = s.tx_second;
	assign LOG_SEND_ALL = reg_val[SB_IDX_DL_SELECT][0];
	assign LOG_DAY_HOUR = reg_val[SB_IDX_DAY_HOUR][4:0];
	assign LOG_TICK = s.log_tick;

endmodule

// ===== verification/sb_settings_properties.sv
// Port assertions for the settings register bank.
`timescale 1ns/1ps
module sb_settings_properties (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_ACK,
	input wire logic REG_ERR,
	input wire logic [15:0] BATT_MV,
	input wire logic LOW_BATTERY,
	input wire logic VALVE_REQ,
	input wire logic VALVE_FULL_ON,
	input wire logic VALVE_PWM_EN,
	input wire logic LOG_TICK
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	// A demand meeting a resting valve, and the valve then being driven.
	sequence valve_start;
		VALVE_REQ && !VALVE_FULL_ON && !VALVE_PWM_EN;
	endsequence
	sequence valve_driven;
		VALVE_FULL_ON || VALVE_PWM_EN;
	endsequence
	// Register port answers and refusals.
	req_answer_a: assert property ((REG_WR || REG_RD) |=> REG_ACK)
		else $error("ack missing");
	err_with_ack_a: assert property (REG_ERR |-> REG_ACK)
		else $error("lone err");
	delay_range_a: assert property (REG_WR && REG_ADDR == 16'h00a4 && REG_WDATA > 16'h03e8 |=> REG_ERR)
		else $error("delay taken");
	// Valve sequence, battery state and log tick; the low thresholds can never sit outside 10000 to 30000 mV.
	valve_start_a: assert property (valve_start |=> valve_driven)
		else $error("valve idle");
	valve_stop_a: assert property ($fell(VALVE_REQ) |=> !VALVE_FULL_ON && !VALVE_PWM_EN)
		else $error("valve on");
	low_enter_a: assert property (!LOW_BATTERY && BATT_MV < 16'h2710 |=> LOW_BATTERY)
		else $error("low missed");
	low_leave_a: assert property (LOW_BATTERY && BATT_MV > 16'h7530 |=> !LOW_BATTERY)
		else $error("low stuck");
	tick_pulse_a: assert property (LOG_TICK |=> !LOG_TICK)
		else $error("tick long");
endmodule
bind sb_settings_bank sb_settings_properties i_props (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_ACK(REG_ACK), .REG_ERR(REG_ERR), .BATT_MV(BATT_MV), .LOW_BATTERY(LOW_BATTERY),
	.VALVE_REQ(VALVE_REQ), .VALVE_FULL_ON(VALVE_FULL_ON), .VALVE_PWM_EN(VALVE_PWM_EN),
	.LOG_TICK(LOG_TICK));

// ===== verification/sb_bus_master.sv
// Field-bus master model issuing register requests.
`timescale 1ns/1ps
module sb_bus_master (
	input wire logic clk,
	output logic wr = 1'b0,
	output logic rd = 1'b0,
	output logic [15:0] addr = 16'h0000,
	output logic [15:0] wd = 16'h0000
);
	// One request per call; calls in a row give back-to-back requests.
	task req(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		wr = w;
		rd = !w;
		addr = a;
		wd = d;
	endtask
	// A released bus shows the inverse of its last value, never a stale copy.
	task idle();
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
		addr = ~addr;
		wd = ~wd;
	endtask
endmodule

// ===== verification/sb_settings_bank_test.sv
// Self-checking bench for the settings register bank.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("BAD %0t %h %h", $time, g, e); end end
module sb_settings_bank_test;
	import sb_pkg::*;
	logic clk, rst, wr, rd, ack, err, low, vreq, vfull, vpwm, send_all, tick;
	logic [15:0] addr, wd, rdata, batt, raw, tx1, tx2, a, lo, hi, v;
	logic [7:0] node;
	logic [4:0] hour;
	logic [19:0] bitc;
	logic [31:0] cal, lfsr = 32'heab06b91;
	logic [16:0] ans, q[$];
	logic signed [15:0] span, zero;
	// Millivolts in the upper bits, expected low-battery state in bit 0.
	logic [16:0] bt[6] = '{17'h059da, 17'h059d9, 17'h061a7, 17'h061a8, 17'h04e1f, 17'h0ea62};
	int failures = 0, n_compared = 0, n, e;
	sb_settings_bank #(.CYCLES_PER_MS(4), .MINUTE_MS(3)) i_dut (
		.SYS_CLK(clk), .SYS_RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
		.REG_WDATA(wd), .REG_RDATA(rdata), .REG_ACK(ack), .REG_ERR(err), .BATT_MV(batt),
		.LOW_BATTERY(low), .VALVE_REQ(vreq), .VALVE_FULL_ON(vfull), .VALVE_PWM_EN(vpwm),
		.NODE_ADDRESS(node), .BIT_CYCLES(bitc), .SENSOR_RAW(raw), .SENSOR_CAL(cal),
		.TX_WORD_FIRST(tx1), .TX_WORD_SECOND(tx2), .LOG_SEND_ALL(send_all),
		.LOG_DAY_HOUR(hour), .LOG_TICK(tick));
	sb_bus_master i_master (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wd(wd));
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[15:0];
	endfunction
	// A request and its expected answer; writes answer with zero data.
	task acc(input logic w, input logic [15:0] ad, input logic [15:0] d, input logic x);
		i_master.req(w, ad, d);
		q.push_back({x, w ? 16'h0000 : d});
	endtask
	// Reads every register back, expects its value after reset, then frees the bus.
	task defaults();
		for (int i = 0; i < SB_NREG; i++)
			acc(1'b0, SB_REG_OFS[i], SB_REG_RST[i], 1'b0);
		i_master.idle();
	endtask
	task valve(input int cyc);
		vreq = 1'b1;
		repeat (cyc) begin
			@(negedge clk);
			`CHK({vfull, vpwm}, 2'b10)
		end
		@(negedge clk);
		`CHK({vfull, vpwm}, 2'b01)
		vreq = 1'b0;
		@(negedge clk);
		`CHK({vfull, vpwm}, 2'b00)
	endtask
	task test_done();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Each answer is matched against the oldest note.
	always @(negedge clk) begin
		if (ack === 1'b1) begin
			ans = q.pop_front();
			`CHK({err, rdata}, ans)
		end
	end
	// The whole run needs a few hundred cycles; this cuts a hang short.
	initial begin
		#40000;
		failures++;
		test_done();
	end
	initial begin
		rst = 1'b1;
		batt = 16'h3000;
		vreq = 1'b0;
		raw = 16'h0000;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		defaults();
		foreach (bt[k]) begin
			batt = bt[k][16:1];
			repeat (2) @(negedge clk);
			`CHK(low, bt[k][0])
		end
		// Random in-range value, both limits, and for unsigned registers one step past the top and past a nonzero bottom.
		for (int i = 0; i < SB_NREG; i++) begin
			a = SB_REG_OFS[i];
			lo = SB_REG_MIN[i];
			hi = SB_REG_MAX[i];
			v = SB_REG_SIGNED[i] ? rnd() : lo + rnd() % (hi - lo + 16'h0001);
			acc(1'b1, a, v, 1'b0);
			acc(1'b0, a, v, 1'b0);
			acc(1'b1, a, hi, 1'b0);
			if (!SB_REG_SIGNED[i])
				acc(1'b1, a, hi + 16'h0001, 1'b1);
			if (!SB_REG_SIGNED[i] && lo != 16'h0000)
				acc(1'b1, a, lo - 16'h0001, 1'b1);
			acc(1'b0, a, hi, 1'b0);
			acc(1'b1, a, lo, 1'b0);
			acc(1'b0, a, lo, 1'b0);
		end
		acc(1'b0, 16'h00a5, 16'h0000, 1'b0);
		acc(1'b1, 16'h00a5, 16'h0001, 1'b1);
		acc(1'b0, 16'h0010, 16'h0000, 1'b1);
		acc(1'b1, 16'h00af, 16'h00f7, 1'b0);
		acc(1'b1, 16'h00b5, 16'h0001, 1'b0);
		acc(1'b1, 16'h00b4, 16'h0017, 1'b0);
		i_master.idle();
		`CHK({node, send_all, hour}, 14'h3df7)
		for (int c = 0; c < 8; c++) begin
			acc(1'b1, 16'h00b0, 16'(c), 1'b0);
			i_master.idle();
			@(negedge clk);
			`CHK(bitc, 20'(250000000 / SB_BAUD[c]))
		end
		span = rnd();
		zero = rnd();
		raw = rnd();
		acc(1'b1, 16'h00b9, span, 1'b0);
		acc(1'b1, 16'h00ba, zero, 1'b0);
		e = ((int'(signed'(raw)) * int'(span)) >>> 10) + int'(zero);
		for (int o = 0; o < 2; o++) begin
			acc(1'b1, 16'h00b1, 16'(o), 1'b0);
			i_master.idle();
			@(negedge clk);
			`CHK(cal, 32'(e))
			`CHK({tx1, tx2}, o ? 32'(e) : {e[15:0], e[31:16]})
		end
		valve(0);
		acc(1'b1, 16'h00a4, 16'h0002, 1'b0);
		i_master.idle();
		valve(8);
		// The third gap is a whole five-minute interval at the new setting.
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (tick !== 1'b1 && n < 2000);
		end
		`CHK(n, 60)
		// A reset in mid-run must bring every setting, the bit period, the calibrated value and both send words back.
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		defaults();
		@(negedge clk);
		`CHK(bitc, 20'(SB_CLK_HZ / SB_BAUD[SB_BIT_RATE_RST]))
		e = (int'(signed'(raw)) * int'(signed'(SB_REG_RST[SB_IDX_SPAN]))) >>> SB_SPAN_SHIFT;
		`CHK(cal, 32'(e))
		`CHK({tx1, tx2}, {e[15:0], e[31:16]})
		`CHK(q.size(), 0)
		test_done();
	end
endmodule
